// [nv_host_ctrl.sv]
// Purpose: host-side controller driving a nonvolatile SRAM through its pins
// Assumes: 20 MHz clock; one request at a time on the user port
// Notes:   reads, writes, software store/recall unlock, hardware store and power-fail busy
//
// How it works
// R1 - Unlock issues reads 0000,1555,0AAA,1FFF,10F0 then 0F0F store or 0F0E recall.
// R2 - Write strobe stays high over all six unlock reads.
// R3 - Device starts the cycle whatever the output-gate level; host keeps gate high.
// R4 - Sixth unlock read returns no data; host ignores the bus then.
// R5 - Device stores on busy-pin request only if written since last cycle.
// R6 - After hardware store, device blocks access until busy pin is high.
// R7 - Host keeps busy pin released through every write cycle.
// R8 - Write strobe low before select means outputs stay off; host drives data.
// R9 - Device lets an in-progress cycle finish at least 1 us before storing.
// R10 - Store lasts up to 10 ms; access waits 700 ns after busy releases.
// R11 - Host pulls busy pin low at least 15 ns to request a store.
// R12 - Device reports busy within 300 ns of the request.
// R13 - Power loss: device pulls busy pin low 1 us; host waits it out.
// R14 - Unwritten at power loss: device releases busy pin, no store.
// R15 - Host holds write strobe and busy pin high during reads.
// R16 - Any other access inside the unlock aborts it.
// R17 - Each unlock step is a chip-select controlled read.
// R18 - Recall clears then reloads the array; host waits the recall time.
// R19 - Select high and busy high puts the device in standby.
// R20 - Select low reads when strobe high, writes when low, 13-bit address.
// R21 - Device tracks a modified flag; host mirrors it for information.
`timescale 1ns/1ps
`default_nettype none
module nv_host_ctrl
    import nv_host_pkg::*;
#(
    parameter int PERSIST_CYCLES = PERSIST_CYC,
    parameter int RECALL_CYCLES  = RECALL_CYC
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              req_valid,
    input  wire op_t               req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output var  logic              rsp_valid,
    output var  logic [DATA_W-1:0] rsp_rdata,
    output var  logic              modified,
    output var  logic              busy_seen,
    output var  logic              chip_sel_n,
    output var  logic              write_str_n,
    output var  logic              out_gate_n,
    output var  logic [ADDR_W-1:0] word_select_lines,
    input  wire logic [DATA_W-1:0] byte_lines_in,
    output var  logic [DATA_W-1:0] byte_lines_out,
    output var  logic              byte_lines_oe,
    input  wire logic              store_busy_pin_n_in,
    output var  logic              store_busy_pin_n_out,
    output var  logic              store_busy_pin_n_oe
);
    typedef enum {ST_IDLE, ST_ACCESS, ST_GAP, ST_HW_PULL, ST_WAIT_BUSY, ST_WAIT_DONE,
                  ST_RECOVER, ST_NV_WAIT} state_t;

    state_t              state;
    logic [CNT_W-1:0]    cnt;
    logic [2:0]          step;
    op_t                 op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                busy_sync;
    logic [DATA_W-1:0]   data_sync;
    logic [DATA_W-1:0]   data_meta;

    nv_sync2 #(.RESET_VAL(1'b1)) u_busy_sync (
        .clk  (clk),
        .srst (srst),
        .d    (store_busy_pin_n_in),
        .q    (busy_sync)
    );

    // Data bus is sampled late in the access, but still passes two flops
    always_ff @(posedge clk) begin
        if (srst) begin
            data_meta <= 8'h00;
            data_sync <= 8'h00;
        end else begin
            data_meta <= byte_lines_in;
            data_sync <= data_meta;
        end
    end

    // Nothing new is accepted while the device signals busy or recovers
    assign req_ready = (state == ST_IDLE) && busy_sync; // [R6] [R13] [R14]

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input op_t o);
        unique case (s)
            3'd0:    seq_addr = SEQ_A0;
            3'd1:    seq_addr = SEQ_A1;
            3'd2:    seq_addr = SEQ_A2;
            3'd3:    seq_addr = SEQ_A3;
            3'd4:    seq_addr = SEQ_A4;
            default: seq_addr = (o == OP_STORE) ? SEQ_STORE : SEQ_RECALL; // [R1]
        endcase
    endfunction : seq_addr

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            cnt   <= '0;
            step  <= 3'd0;
            op    <= OP_READ;
            addr  <= '0;
            wdata <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (!busy_sync) begin
                        // Power-fail busy from the device: wait until it lets go
                        state <= ST_WAIT_DONE; // [R13] [R14]
                        cnt   <= '0;
                    end else if (req_valid) begin
                        op    <= req_op;
                        addr  <= req_addr;
                        wdata <= req_wdata;
                        step  <= 3'd0;
                        cnt   <= '0;
                        if (req_op == OP_STORE && req_addr[0]) begin
                            // Low address bit selects the hardware pin request
                            state <= ST_HW_PULL;
                        end else begin
                            state <= ST_ACCESS;
                        end
                    end
                end
                ST_ACCESS: begin
                    if (cnt == CNT_W'(ACCESS_CYC + 2)) begin
                        cnt   <= '0;
                        state <= ST_GAP;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_GAP: begin
                    // Select goes high between steps so each step is select-clocked
                    if (op == OP_STORE || op == OP_RECALL) begin
                        if (step == 3'd5) begin
                            state <= ST_NV_WAIT;
                            cnt   <= '0;
                        end else begin
                            step  <= step + 1'b1; // [R16] no other access interleaves
                            state <= ST_ACCESS;
                        end
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_HW_PULL: begin
                    if (cnt == CNT_W'(STORE_PULSE_CYC)) begin // [R11]
                        cnt   <= '0;
                        state <= ST_WAIT_BUSY;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_WAIT_BUSY: begin
                    // No busy within the report window means the store was skipped
                    if (!busy_sync) begin
                        cnt   <= '0;
                        state <= ST_WAIT_DONE;
                    end else if (cnt == CNT_W'(BUSY_REPORT_CYC + 2)) begin // [R12] [R5]
                        cnt   <= '0;
                        state <= ST_RECOVER;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_WAIT_DONE: begin
                    if (busy_sync) begin
                        cnt   <= '0;
                        state <= ST_RECOVER; // [R6]
                    end else if (cnt != CNT_W'(PERSIST_CYCLES)) begin
                        cnt <= cnt + 1'b1; // [R10] [R9]
                    end
                end
                ST_RECOVER: begin
                    if (cnt == CNT_W'(INHIBIT_REL_CYC)) begin // [R10]
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_NV_WAIT: begin
                    if ((op == OP_STORE && cnt == CNT_W'(PERSIST_CYCLES)) ||
                        (op == OP_RECALL && cnt == CNT_W'(RECALL_CYCLES))) begin // [R18] [R10]
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pin drive, all from flops
    always_ff @(posedge clk) begin
        if (srst) begin
            chip_sel_n        <= 1'b1;
            write_str_n       <= 1'b1;
            out_gate_n        <= 1'b1;
            word_select_lines <= '0;
            byte_lines_out    <= '0;
            byte_lines_oe     <= 1'b0;
        end else begin
            chip_sel_n    <= 1'b1; // [R19]
            write_str_n   <= 1'b1; // [R2] [R15] [R7]
            out_gate_n    <= 1'b1;
            byte_lines_oe <= 1'b0;
            if (state == ST_ACCESS) begin
                chip_sel_n <= 1'b0; // [R17] [R20]
                if (op == OP_WRITE) begin
                    // Strobe and data go down with select so the device never drives
                    write_str_n       <= (cnt == CNT_W'(ACCESS_CYC + 2)); // [R8]
                    byte_lines_oe     <= 1'b1;
                    byte_lines_out    <= wdata;
                    word_select_lines <= addr;
                end else if (op == OP_READ) begin
                    out_gate_n        <= 1'b0; // [R15]
                    word_select_lines <= addr;
                end else begin
                    // Gate kept high: the unlock does not need read data
                    word_select_lines <= seq_addr(step, op); // [R1] [R3] [R4]
                end
            end
        end
    end

    assign store_busy_pin_n_out = 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            store_busy_pin_n_oe <= 1'b0;
        end else begin
            store_busy_pin_n_oe <= (state == ST_HW_PULL); // [R11] [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == ST_GAP && op == OP_READ) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_sync;
            end else if (state != ST_IDLE && state != ST_ACCESS && state != ST_GAP &&
                         state != ST_HW_PULL && state != ST_WAIT_BUSY) begin
                rsp_valid <= (state == ST_RECOVER && cnt == CNT_W'(INHIBIT_REL_CYC)) ||
                             (state == ST_NV_WAIT &&
                              ((op == OP_STORE && cnt == CNT_W'(PERSIST_CYCLES)) ||
                               (op == OP_RECALL && cnt == CNT_W'(RECALL_CYCLES))));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            modified  <= 1'b0;
            busy_seen <= 1'b0;
        end else begin
            busy_seen <= !busy_sync;
            if (state == ST_GAP && op == OP_WRITE) begin
                modified <= 1'b1; // [R21]
            end else if (state == ST_RECOVER || state == ST_NV_WAIT) begin
                modified <= 1'b0; // [R21]
            end
        end
    end
endmodule : nv_host_ctrl
`default_nettype wire

// [nv_host_pkg.sv]
// Purpose: constants for the host controller of a store/recall nonvolatile SRAM
// Assumes: 20 MHz clock, 50 ns period
// Notes:   times are kept in their printed units and converted to cycles here
package nv_host_pkg;
    localparam int CLK_PERIOD_PS = 50000;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // Unlock sequence addresses
    localparam logic [12:0] SEQ_A0 = 13'h0000;
    localparam logic [12:0] SEQ_A1 = 13'h1555;
    localparam logic [12:0] SEQ_A2 = 13'h0aaa;
    localparam logic [12:0] SEQ_A3 = 13'h1fff;
    localparam logic [12:0] SEQ_A4 = 13'h10f0;
    localparam logic [12:0] SEQ_STORE  = 13'h0f0f;
    localparam logic [12:0] SEQ_RECALL = 13'h0f0e;
    // Times in ns, except the store time in ms and the recall time in us
    localparam int ACCESS_NS          = 45;
    localparam int STORE_PULSE_NS     = 15;
    localparam int BUSY_REPORT_NS     = 300;
    localparam int INHIBIT_RELEASE_NS = 700;
    localparam int PERSIST_MS         = 10;
    localparam int RECALL_US          = 20;
    // Least times round up, a minimum of one cycle
    localparam int ACCESS_CYC       = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STORE_PULSE_CYC  = (STORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BUSY_REPORT_CYC  = (BUSY_REPORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INHIBIT_REL_CYC  = (INHIBIT_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Divide first for the store time: its product in picoseconds would not fit in 32 bits
    localparam int PERSIST_CYC      = (PERSIST_MS * (1000000000 / CLK_PERIOD_PS)) + 1;
    localparam int RECALL_CYC       = (RECALL_US * 1000000 / CLK_PERIOD_PS) + 1;
    localparam int CNT_W = 20;
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_STORE, OP_RECALL} op_t;
endpackage : nv_host_pkg

// [nv_sync2.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single-bit level input from outside the clock domain
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module nv_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic d,
    output var  logic q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : nv_sync2
`default_nettype wire

// [nv_host_properties.sv]
// Purpose: pin and handshake checks on nv_host_ctrl
// Assumes: one clock, srst active high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module nv_host_properties
    import nv_host_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire op_t  req_op,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic busy_seen,
    input wire logic chip_sel_n,
    input wire logic write_str_n,
    input wire logic out_gate_n,
    input wire logic byte_lines_oe,
    input wire logic store_busy_pin_n_out,
    input wire logic store_busy_pin_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    int unsigned since;
    // Sync delay of busy_seen is three cycles, so the device clock starts earlier
    always_ff @(posedge clk) begin
        if (srst) since <= 100;
        else if (busy_seen) since <= 0;
        else if (since < 100) since <= since + 1;
    end
    AST_READ_BUSY: assert property (!chip_sel_n && write_str_n |-> !store_busy_pin_n_oe)
        else $error("busy pin pulled during a read");
    AST_WRITE_BUSY: assert property (!chip_sel_n && !write_str_n |-> !store_busy_pin_n_oe && byte_lines_oe)
        else $error("write without data drive or with busy pulled");
    AST_GATE_WRITE: assert property (!write_str_n |-> out_gate_n)
        else $error("output gate low during write");
    AST_PULL_LEN: assert property ($rose(store_busy_pin_n_oe) |=> store_busy_pin_n_oe ##1 !store_busy_pin_n_oe)
        else $error("store request pulse length wrong");
    AST_PULL_LOW: assert property (store_busy_pin_n_oe |-> !store_busy_pin_n_out)
        else $error("busy pin driven high");
    AST_NO_TAKE_BUSY: assert property (busy_seen |-> !req_ready)
        else $error("request taken while device busy");
    AST_RECOVER: assert property (!chip_sel_n |-> since >= INHIBIT_REL_CYC - 2)
        else $error("access before inhibit release time");
    AST_READ_RSP: assert property (req_valid && req_ready && req_op == OP_READ |-> ##6 rsp_valid)
        else $error("read answer late or missing");
    COV_READ: cover property (rsp_valid);
    COV_PULL: cover property ($rose(store_busy_pin_n_oe));
    COV_BUSY: cover property ($fell(busy_seen));
endmodule : nv_host_properties
`default_nettype wire

// [nv_dev_model.sv]
// Purpose: behavioural store/recall SRAM facing the host controller
// Assumes: active-low pins, open-drain busy pin with pull-up
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module nv_dev_model
    import nv_host_pkg::*;
#(
    parameter int BUSY_NS = 40,
    parameter int NV_NS   = 800
) (
    input  wire logic              chip_sel_n,
    input  wire logic              write_str_n,
    input  wire logic              out_gate_n,
    input  wire logic [ADDR_W-1:0] word_select_lines,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic              host_oe,
    input  wire logic              busy_level,
    input  wire logic              pwr_fail,
    output var  logic [DATA_W-1:0] byte_level,
    output var  logic              dev_pull
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] nv  [2**ADDR_W];
    logic [DATA_W-1:0] last, d_q;
    logic [ADDR_W-1:0] a_q;
    logic [ADDR_W-1:0] seq [5];
    logic written = 0, wr = 0, nv_busy = 0;
    int step = 0, store_count = 0, recall_count = 0;
    wire inhibit = nv_busy || !busy_level;
    wire fin = step == 5 && (word_select_lines == SEQ_STORE || word_select_lines == SEQ_RECALL);
    wire dev_oe = !chip_sel_n && write_str_n && !out_gate_n && !inhibit && !fin;
    initial seq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    initial dev_pull = 0;
    always @* if (host_oe) last = host_data; else if (dev_oe) last = mem[word_select_lines];
    assign byte_level = host_oe ? host_data : dev_oe ? mem[word_select_lines] : ~last;
    // Sampled after the edges so the host's same-edge changes never race
    always @(negedge chip_sel_n) #5 a_q = word_select_lines;
    always @(negedge write_str_n) #20 d_q = byte_level;
    task automatic nv_cycle(input logic keep);
        nv_busy = 1;
        if (keep) begin
            nv = mem;
            store_count++;
        end else begin
            mem = '{default: '0};
            mem = nv;
            recall_count++;
        end
        written = 0;
        #(NV_NS) nv_busy = 0;
    endtask : nv_cycle
    always @(posedge write_str_n) if (!chip_sel_n && !inhibit) begin
        mem[a_q] = d_q;
        written = 1;
        wr = 1;
        step = 0;
    end
    always @(posedge chip_sel_n) begin
        if (wr) wr = 0;
        else if (!inhibit) begin
            if (step == 5 && (a_q == SEQ_STORE || a_q == SEQ_RECALL)) begin
                step = 0;
                nv_cycle(a_q == SEQ_STORE);
            end else if (step < 5 && a_q == seq[step]) step++;
            else step = int'(a_q == SEQ_A0);
        end
    end
    always @(negedge busy_level) if (!dev_pull && !pwr_fail) begin
        #(BUSY_NS) dev_pull = 1;
        if (written) nv_cycle(1);
        else #(NV_NS);
        dev_pull = 0;
    end
    always @(posedge pwr_fail) begin
        dev_pull = 1;
        #1000;
        if (written) nv_cycle(1);
        dev_pull = 0;
    end
endmodule : nv_dev_model
`default_nettype wire

// [nvsram_store_recall_control_bench.sv]
// Purpose: self-checking bench for nv_host_ctrl against a device model
// Assumes: 20 MHz clock, shortened store and recall counts
// Notes:   power loss is raised only while the host is idle
`timescale 1ns/1ps
`default_nettype none
module nvsram_store_recall_control_bench
    import nv_host_pkg::*;
;
    logic clk, srst, req_valid, pwr_fail, rsp_valid, req_ready, modified, busy_seen;
    logic chip_sel_n, write_str_n, out_gate_n, byte_lines_oe, busy_out, busy_oe, dev_pull;
    op_t req_op;
    logic [ADDR_W-1:0] req_addr, word_select_lines;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, byte_lines_in, byte_lines_out;
    logic [DATA_W-1:0] wr_data [8];
    logic [ADDR_W-1:0] wr_addr [8];
    int errors = 0, check_count = 0, cycles = 0, n0;
    wire busy_level = !(busy_oe && !busy_out) && !dev_pull;
    nv_host_ctrl #(.PERSIST_CYCLES(50), .RECALL_CYCLES(20)) i_nv_host_ctrl (.clk, .srst, .req_valid,
        .req_op, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .modified, .busy_seen,
        .chip_sel_n, .write_str_n, .out_gate_n, .word_select_lines, .byte_lines_in, .byte_lines_out,
        .byte_lines_oe, .store_busy_pin_n_in(busy_level), .store_busy_pin_n_out(busy_out),
        .store_busy_pin_n_oe(busy_oe));
    nv_dev_model i_nv_dev_model (.chip_sel_n, .write_str_n, .out_gate_n, .word_select_lines,
        .host_data(byte_lines_out), .host_oe(byte_lines_oe), .busy_level, .pwr_fail,
        .byte_level(byte_lines_in), .dev_pull);
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] after_store(input int c, input logic w);
        return 8'(c + int'(w));
    endfunction : after_store
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic do_req(input op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        if (op != OP_WRITE) do @(negedge clk); while (rsp_valid !== 1'b1);
    endtask : do_req
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        {srst, req_valid, pwr_fail, req_addr, req_wdata} = {3'b100, 21'h0};
        req_op = OP_READ;
        n0 = $urandom(90942);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            wr_addr[i] = {3'(i), (i == 7) ? 10'h3ff : 10'($urandom)};
            wr_data[i] = 8'($urandom);
            do_req(OP_WRITE, wr_addr[i], wr_data[i]);
            do_req(OP_READ, wr_addr[i], 8'h00);
            check(rsp_rdata, wr_data[i]);
        end
        check({7'h0, modified}, 8'h01);
        n0 = i_nv_dev_model.store_count;
        do_req(OP_STORE, 13'h0000, 8'h00);
        check(8'(i_nv_dev_model.store_count), after_store(n0, 1'b1));
        check({7'h0, modified}, 8'h00);
        do_req(OP_WRITE, wr_addr[0], ~wr_data[0]);
        do_req(OP_RECALL, 13'h0000, 8'h00);
        check(8'(i_nv_dev_model.recall_count), 8'h01);
        do_req(OP_READ, wr_addr[0], 8'h00);
        check(rsp_rdata, wr_data[0]);
        for (int k = 0; k < 2; k++) begin
            n0 = i_nv_dev_model.store_count;
            if (k == 1) do_req(OP_WRITE, wr_addr[1], 8'h5a);
            do_req(OP_STORE, 13'h0001, 8'h00);
            check(8'(i_nv_dev_model.store_count), after_store(n0, k == 1));
            do_req(OP_READ, wr_addr[1], 8'h00);
            check(rsp_rdata, (k == 1) ? 8'h5a : wr_data[1]);
        end
        for (int k = 0; k < 2; k++) begin
            n0 = i_nv_dev_model.store_count;
            if (k == 1) do_req(OP_WRITE, wr_addr[2], 8'ha5);
            // The write must have landed before the supply drops
            do @(negedge clk); while (req_ready !== 1'b1);
            @(posedge clk) pwr_fail <= 1'b1;
            repeat (10) @(posedge clk);
            @(negedge clk);
            check({6'h0, busy_seen, req_ready}, 8'h02);
            @(posedge clk) pwr_fail <= 1'b0;
            do_req(OP_READ, wr_addr[3], 8'h00);
            check(rsp_rdata, wr_data[3]);
            check(8'(i_nv_dev_model.store_count), after_store(n0, k == 1));
        end
        summarize();
    end
endmodule : nvsram_store_recall_control_bench
bind nv_host_ctrl nv_host_properties i_nv_host_properties (.clk, .srst, .req_valid, .req_op, .req_ready,
    .rsp_valid, .busy_seen, .chip_sel_n, .write_str_n, .out_gate_n, .byte_lines_oe,
    .store_busy_pin_n_out, .store_busy_pin_n_oe);
`default_nettype wire
